/* hdl/brpa_agu.sv */
`timescale 1ns/1ps
// Operation
// [RQ1] Bit-reverse increment: issue pointer, then add step, carry reversed.
// [RQ2] Bit-reverse decrement: issue pointer, subtract step, borrow reversed.
// [RQ3] Compat bit set: extended pointer zero is the step, else first index.
// [RQ4] Bit-reverse update never wraps inside a circular buffer.
// [RQ5] Circular config adds zero-extended buffer start to pointer address.
// [RQ6] Bit-reverse decrement keeps linear update under circular config.
// [RQ7] Linear mode address: high part, optional buffer start, plus low part.
// [RQ8] Linear mode uses unmodified pointer, then adds second index normally.
// [RQ9] Single read uses pre-modification pointer, word to named register.
// [RQ10] Double word second address is first plus one if even, else minus one.
// [RQ11] First word goes to first register of pair, second to next register.
// [RQ12] Double access updates pointer once, after both addresses, same step.
// [RQ13] Reverse carry: reverse operands, add or subtract, reverse result.
module brpa_agu
    import brpa_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Request from decoder
    input wire logic REQ_VALID,
    input wire brpa_op_t REQ_OP,
    input wire logic REQ_DOUBLE,
    input wire logic [REG_W-1:0] REQ_DST,
    input wire logic [PTR_W-1:0] PTR_IN,
    input wire logic [WORD_W-1:0] FIRST_INDEX_REG,
    input wire logic [WORD_W-1:0] SECOND_INDEX_REG,
    input wire logic [PTR_W-1:0] EXTENDED_AUX_POINTER_ZERO,
    input wire logic [WORD_W-1:0] BUFFER_START_REG,
    input wire logic CIRCULAR_CFG,
    input wire logic LEGACY_COMPAT_MODE_BIT,
    // Status
    output logic BUSY,
    // Data read bus
    output logic RD_REQ,
    output logic [PTR_W-1:0] RD_ADDR,
    input wire logic [WORD_W-1:0] RD_DATA,
    // Destination write
    output logic DST_WE,
    output logic [REG_W-1:0] DST_SEL,
    output logic [WORD_W-1:0] DST_DATA,
    // Pointer write back
    output logic PTR_WE,
    output logic [PTR_W-1:0] PTR_OUT
);

    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    brpa_state_t state;
    brpa_state_t next_state;
    logic [PTR_W-1:0] base_addr;
    logic [PTR_W-1:0] upd_ptr;
    logic [REG_W-1:0] dst_reg;
    logic dbl;
    logic rd_pend;
    logic [REG_W-1:0] rd_reg;

    // ------------------------------------------------------------
    // Step selection and arithmetic
    // ------------------------------------------------------------
    wire logic [PTR_W-1:0] first_idx_ext;
    wire logic [PTR_W-1:0] second_idx_ext;
    wire logic [PTR_W-1:0] bitrev_step;
    wire logic [PTR_W-1:0] ptr_rev;
    wire logic [PTR_W-1:0] step_rev;
    wire logic [PTR_W-1:0] sum_rev;
    wire logic [PTR_W-1:0] diff_rev;
    wire logic [PTR_W-1:0] br_sum;
    wire logic [PTR_W-1:0] br_diff;
    wire logic [PTR_W-1:0] lin_sum;
    wire logic [PTR_W-1:0] bsa_ext;
    wire logic [PTR_W-1:0] low_off;
    wire logic [PTR_W-1:0] req_addr;
    wire logic [PTR_W-1:0] req_upd;
    wire logic [PTR_W-1:0] second_addr;
    wire logic last_rd;

    assign first_idx_ext = {{(PTR_W-WORD_W){FIRST_INDEX_REG[WORD_W-1]}},
                            FIRST_INDEX_REG};
    assign second_idx_ext = {{(PTR_W-WORD_W){SECOND_INDEX_REG[WORD_W-1]}},
                             SECOND_INDEX_REG};
    assign bitrev_step = LEGACY_COMPAT_MODE_BIT ?
                         EXTENDED_AUX_POINTER_ZERO : first_idx_ext; // RQ3

    genvar i;
    generate
        for (i = 0; i < PTR_W; i++)
        begin : g_rev
            assign ptr_rev[i] = PTR_IN[PTR_W-1-i]; // RQ13
            assign step_rev[i] = bitrev_step[PTR_W-1-i]; // RQ13
            assign br_sum[i] = sum_rev[PTR_W-1-i]; // RQ13
            assign br_diff[i] = diff_rev[PTR_W-1-i]; // RQ13
        end
    endgenerate

    assign sum_rev = ptr_rev + step_rev; // RQ1
    assign diff_rev = ptr_rev - step_rev; // RQ2
    assign lin_sum = PTR_IN + second_idx_ext; // RQ8

    // Buffer start zero-extended under circular config, else zero; added to the low part in linear mode, to the whole pointer otherwise
    assign bsa_ext = CIRCULAR_CFG ?
                     {{(PTR_W-WORD_W){1'b0}}, BUFFER_START_REG} :
                     {PTR_W{1'b0}}; // RQ5
    assign low_off = {{(PTR_W-LOW_W){1'b0}}, PTR_IN[LOW_W-1:0]} + bsa_ext;
    assign req_addr = (REQ_OP == BRPA_OP_LIN_INC) ?
                      {PTR_IN[PTR_W-1:LOW_W], {LOW_W{1'b0}}} + low_off : // RQ7
                      PTR_IN + bsa_ext; // RQ5

    // Updates ignore the circular buffer entirely
    assign req_upd = (REQ_OP == BRPA_OP_BR_INC) ? br_sum : // RQ4
                     (REQ_OP == BRPA_OP_BR_DEC) ? br_diff : // RQ6
                     lin_sum; // RQ8

    assign second_addr = base_addr[0] ?
                         base_addr - {{(PTR_W-1){1'b0}}, 1'b1} :
                         base_addr + {{(PTR_W-1){1'b0}}, 1'b1}; // RQ10

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            BRPA_IDLE:
                if (REQ_VALID)
                    next_state = BRPA_FIRST;
            BRPA_FIRST:
                next_state = dbl ? BRPA_SECOND : BRPA_IDLE;
            BRPA_SECOND:
                next_state = BRPA_IDLE;
        endcase
    end

    assign BUSY = (state != BRPA_IDLE);
    assign RD_REQ = (state == BRPA_FIRST) || (state == BRPA_SECOND);
    // Last address of the access is on the bus
    assign last_rd = (state == BRPA_SECOND) || (state == BRPA_FIRST && !dbl);

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            state <= BRPA_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            base_addr <= PTR_RST;
            upd_ptr <= PTR_RST;
            dst_reg <= REG_RST;
            dbl <= 1'b0;
        end
        else if (state == BRPA_IDLE && REQ_VALID)
        begin
            base_addr <= req_addr; // RQ9
            upd_ptr <= req_upd;
            dst_reg <= REQ_DST;
            dbl <= REQ_DOUBLE;
        end
    end

    // ------------------------------------------------------------
    // Address output
    // ------------------------------------------------------------
    always_comb
    begin
        RD_ADDR = base_addr; // RQ1 RQ2 RQ8
        if (state == BRPA_SECOND)
            RD_ADDR = second_addr; // RQ10
    end

    // ------------------------------------------------------------
    // Read return and pointer write back
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            rd_pend <= 1'b0;
            rd_reg <= REG_RST;
        end
        else
        begin
            rd_pend <= RD_REQ;
            rd_reg <= (state == BRPA_SECOND) ?
                      dst_reg + 5'h01 : dst_reg; // RQ11
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            DST_WE <= 1'b0;
            DST_SEL <= REG_RST;
            DST_DATA <= WORD_RST;
        end
        else
        begin
            DST_WE <= rd_pend;
            DST_SEL <= rd_reg; // RQ9 RQ11
            DST_DATA <= RD_DATA;
        end
    end

    // Single write back after the last address has been issued
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            PTR_WE <= 1'b0;
            PTR_OUT <= PTR_RST;
        end
        else
        begin
            PTR_WE <= RD_REQ && last_rd; // RQ12
            PTR_OUT <= upd_ptr;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_first_addr;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_IDLE && REQ_VALID && !CIRCULAR_CFG
         && REQ_OP != BRPA_OP_LIN_INC)
        |=> RD_REQ && RD_ADDR == $past(PTR_IN);
    endproperty
    a_first_addr: assert property (p_first_addr) // RQ1
        else $error("first address not the pointer");

    property p_br_inc;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_IDLE && REQ_VALID && REQ_OP == BRPA_OP_BR_INC
         && !REQ_DOUBLE) |=> ##1 PTR_WE && PTR_OUT == $past(br_sum, 2);
    endproperty
    a_br_inc: assert property (p_br_inc) // RQ13
        else $error("bit-reverse increment result wrong");

    property p_br_dec;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_IDLE && REQ_VALID && REQ_OP == BRPA_OP_BR_DEC
         && !REQ_DOUBLE) |=> ##1 PTR_OUT == $past(br_diff, 2);
    endproperty
    a_br_dec: assert property (p_br_dec) // RQ2
        else $error("bit-reverse decrement result wrong");

    property p_step_sel;
        @(posedge CLK) disable iff (!RESETN)
        LEGACY_COMPAT_MODE_BIT |-> bitrev_step == EXTENDED_AUX_POINTER_ZERO;
    endproperty
    a_step_sel: assert property (p_step_sel) // RQ3
        else $error("compat step not pointer zero");

    property p_lin_inc;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_IDLE && REQ_VALID && REQ_OP == BRPA_OP_LIN_INC
         && REQ_DOUBLE) |=> ##2 PTR_WE && PTR_OUT == $past(lin_sum, 3);
    endproperty
    a_lin_inc: assert property (p_lin_inc) // RQ8
        else $error("linear increment result wrong");

    property p_second_addr;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_FIRST && dbl) |=> RD_REQ &&
        RD_ADDR == ($past(RD_ADDR) ^ 23'h000001);
    endproperty
    a_second_addr: assert property (p_second_addr) // RQ10
        else $error("second address not adjacent");

    property p_pair_dst;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_SECOND) |=> ##1 DST_WE &&
        DST_SEL == $past(dst_reg, 2) + 5'h01;
    endproperty
    a_pair_dst: assert property (p_pair_dst) // RQ11
        else $error("second word to wrong register");

    property p_one_update;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_FIRST && dbl) |=> !PTR_WE ##1 PTR_WE;
    endproperty
    a_one_update: assert property (p_one_update) // RQ12
        else $error("double access pointer update timing");

    property p_circ_addr;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_IDLE && REQ_VALID && CIRCULAR_CFG
         && REQ_OP != BRPA_OP_LIN_INC)
        |=> RD_REQ && RD_ADDR == $past(PTR_IN) +
            {{(PTR_W-WORD_W){1'b0}}, $past(BUFFER_START_REG)};
    endproperty
    a_circ_addr: assert property (p_circ_addr) // RQ5
        else $error("circular bit-reverse address wrong");

    property p_lin_addr;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_IDLE && REQ_VALID && REQ_OP == BRPA_OP_LIN_INC)
        |=> RD_REQ && RD_ADDR == $past(PTR_IN) + ($past(CIRCULAR_CFG) ?
            {{(PTR_W-WORD_W){1'b0}}, $past(BUFFER_START_REG)} :
            {PTR_W{1'b0}});
    endproperty
    a_lin_addr: assert property (p_lin_addr) // RQ7
        else $error("linear address wrong");

    property p_br_no_wrap;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_IDLE && REQ_VALID && CIRCULAR_CFG
         && REQ_OP == BRPA_OP_BR_INC) |=> upd_ptr == $past(br_sum);
    endproperty
    a_br_no_wrap: assert property (p_br_no_wrap) // RQ4
        else $error("bit-reverse increment wrapped in buffer");

    property p_dec_linear;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_IDLE && REQ_VALID && CIRCULAR_CFG
         && REQ_OP == BRPA_OP_BR_DEC) |=> upd_ptr == $past(br_diff);
    endproperty
    a_dec_linear: assert property (p_dec_linear) // RQ6
        else $error("bit-reverse decrement kept in buffer");

    property p_single_read;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_FIRST && !dbl) |=> ##1 DST_WE &&
        DST_SEL == $past(dst_reg, 2) && DST_DATA == $past(RD_DATA);
    endproperty
    a_single_read: assert property (p_single_read) // RQ9
        else $error("single read word not delivered");

    property p_pair_first;
        @(posedge CLK) disable iff (!RESETN)
        (state == BRPA_FIRST && dbl) |=> ##1 DST_WE &&
        DST_SEL == $past(dst_reg, 2);
    endproperty
    a_pair_first: assert property (p_pair_first) // RQ11
        else $error("first word to wrong register");

    property p_step_first;
        @(posedge CLK) disable iff (!RESETN)
        !LEGACY_COMPAT_MODE_BIT |-> bitrev_step ==
        {{(PTR_W-WORD_W){FIRST_INDEX_REG[WORD_W-1]}}, FIRST_INDEX_REG};
    endproperty
    a_step_first: assert property (p_step_first) // RQ3
        else $error("step not first index");

    property p_no_retake;
        @(posedge CLK) disable iff (!RESETN)
        (state != BRPA_IDLE) |=> $stable(upd_ptr) && $stable(dst_reg);
    endproperty
    a_no_retake: assert property (p_no_retake) // RQ12
        else $error("request taken while busy");

endmodule

/* hdl/brpa_pkg.sv */
package brpa_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PTR_W = 23;
    localparam int LOW_W = 16;
    localparam int HIGH_W = 7;
    localparam int WORD_W = 16;
    localparam int REG_W = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PTR_W-1:0] PTR_RST = 23'h000000;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [REG_W-1:0] REG_RST = 5'h00;

    // ------------------------------------------------------------
    // Operand kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        BRPA_OP_BR_INC,
        BRPA_OP_BR_DEC,
        BRPA_OP_LIN_INC
    } brpa_op_t;

    typedef enum
    {
        BRPA_IDLE,
        BRPA_FIRST,
        BRPA_SECOND
    } brpa_state_t;

endpackage

/* verif/brpa_mem_model.sv */
`timescale 1ns/1ps
module brpa_mem_model
    import brpa_pkg::*;
(
    // Clock
    input wire logic clk,
    // Data read bus
    input wire logic rd_req,
    input wire logic [PTR_W-1:0] rd_addr,
    output logic [WORD_W-1:0] rd_data
);
    // ------------------------------------------------------------
    // Word one cycle after the read, toggling garbage otherwise
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rd_req)
            rd_data <= rd_addr[WORD_W-1:0] ^ 16'h5a5a;
        else
            rd_data <= ~rd_data;
    end
endmodule

/* verif/bit_reverse_pointer_agu_tb.sv */
`timescale 1ns/1ps
module bit_reverse_pointer_agu_tb;
    import brpa_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk, resetn, req_valid, req_double, circ, cm;
    brpa_op_t req_op;
    logic [REG_W-1:0] req_dst, dst_sel;
    logic [PTR_W-1:0] ptr_in, x0, rd_addr, ptr_out;
    logic [WORD_W-1:0] t0, t1, bsa, rd_data, dst_data;
    logic busy, rd_req, dst_we, ptr_we;
    int failures, tests_run;

    brpa_agu dut_u (.CLK(clk), .RESETN(resetn), .REQ_VALID(req_valid),
        .REQ_OP(req_op), .REQ_DOUBLE(req_double), .REQ_DST(req_dst),
        .PTR_IN(ptr_in), .FIRST_INDEX_REG(t0), .SECOND_INDEX_REG(t1),
        .EXTENDED_AUX_POINTER_ZERO(x0), .BUFFER_START_REG(bsa),
        .CIRCULAR_CFG(circ), .LEGACY_COMPAT_MODE_BIT(cm), .BUSY(busy),
        .RD_REQ(rd_req), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
        .DST_WE(dst_we), .DST_SEL(dst_sel), .DST_DATA(dst_data),
        .PTR_WE(ptr_we), .PTR_OUT(ptr_out));

    brpa_mem_model mem_u (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_data(rd_data));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [PTR_W-1:0] rev(input logic [PTR_W-1:0] v);
        logic [PTR_W-1:0] r;
        for (int i = 0; i < PTR_W; i++)
            r[i] = v[PTR_W-1-i];
        return r;
    endfunction

    task automatic check_ptr(input string n, input logic [PTR_W-1:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_word(input string n, input logic [WORD_W-1:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One request, held a second cycle while busy so it must be ignored
    task automatic run_op(input brpa_op_t op, input logic dbl,
        input logic [PTR_W-1:0] p, z, input logic [WORD_W-1:0] k, s);
        logic [PTR_W-1:0] st, ea, na;
        logic [REG_W-1:0] ds;
        logic [PTR_W-1:0] aq[$], pq[$];
        logic [WORD_W-1:0] dq[$], sq[$];
        int rc, pc;
        st = (z != 0) ? z : {{HIGH_W{k[WORD_W-1]}}, k};
        if (op == BRPA_OP_LIN_INC)
            na = p + {{HIGH_W{k[WORD_W-1]}}, k};
        else if (op == BRPA_OP_BR_INC)
            na = rev(rev(p) + rev(st));
        else
            na = rev(rev(p) - rev(st));
        ea = p + ((s != 0) ? {{HIGH_W{1'b0}}, s} : PTR_RST);
        ds = p[REG_W-1:0] ^ 5'h0a;
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_double <= dbl;
        req_dst <= ds;
        ptr_in <= p;
        t0 <= (op == BRPA_OP_LIN_INC) ? ~k : k;
        t1 <= (op == BRPA_OP_LIN_INC) ? k : ~k;
        x0 <= z;
        cm <= (z != 0);
        bsa <= s;
        circ <= (s != 0);
        for (int i = 0; i < 6; i++)
        begin
            @(negedge clk);
            if (rd_req === 1'b1)
                aq.push_back(rd_addr);
            if (rd_req === 1'b1)
                rc = i;
            if (dst_we === 1'b1)
                dq.push_back(dst_data);
            if (dst_we === 1'b1)
                sq.push_back(WORD_W'(dst_sel));
            if (ptr_we === 1'b1)
                pq.push_back(ptr_out);
            if (ptr_we === 1'b1)
                pc = i;
            if (i == 1)
                check_word("busy", 16'h0001, WORD_W'(busy));
            @(posedge clk);
            if (i == 1)
                req_valid <= 1'b0;
        end
        check_word("reads", 16'(dbl) + 16'h0001, WORD_W'(aq.size()));
        check_ptr("addr0", ea, aq[0]);
        check_word("data0", ea[WORD_W-1:0] ^ 16'h5a5a, dq[0]);
        check_word("sel0", WORD_W'(ds), sq[0]);
        check_ptr("ptr", na, pq[0]);
        check_word("ptr writes", 16'h0001, WORD_W'(pq.size()));
        check_word("ptr after reads", WORD_W'(rc + 1), WORD_W'(pc));
        if (dbl)
        begin
            check_ptr("addr1", ea ^ 23'h000001, aq[1]);
            check_word("data1", ea[WORD_W-1:0] ^ 16'h5a5b, dq[1]);
            check_word("sel1", WORD_W'(REG_W'(ds + 5'h01)), sq[1]);
        end
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog, tests
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        #(40 * 2000);
        failures++;
        tally_and_finish();
    end

    initial
    begin
        {resetn, req_valid, req_double, circ, cm} = 5'h00;
        req_op = BRPA_OP_BR_INC;
        {req_dst, ptr_in, x0} = '0;
        {t0, t1, bsa} = '0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check_word("idle", 16'h0000, {12'h000, busy, rd_req, dst_we, ptr_we});
        run_op(BRPA_OP_BR_INC, 1'b0, 23'h000018, 23'h0,
            16'h0008, 16'h0);
        run_op(BRPA_OP_BR_DEC, 1'b1, 23'h000035, 23'h0,
            16'h0004, 16'h0);
        run_op(BRPA_OP_BR_INC, 1'b1, 23'h412340, 23'h000020,
            16'h0001, 16'h0);
        run_op(BRPA_OP_BR_INC, 1'b0, 23'h7f0f00, 23'h0,
            16'h0100, 16'h8100);
        run_op(BRPA_OP_BR_DEC, 1'b0, 23'h000003, 23'h0,
            16'h0002, 16'h0010);
        run_op(BRPA_OP_LIN_INC, 1'b0, 23'h010004, 23'h0,
            16'hfffe, 16'h0020);
        run_op(BRPA_OP_LIN_INC, 1'b1, 23'h00fffe, 23'h0,
            16'h0003, 16'h0);
        tally_and_finish();
    end
endmodule
